// ===== core/adc_command_status_sequencer.sv
// Serial command decoding, output register selection and conversion control
`timescale 1ns/1ps

// Overview of operation
// - select bits D1, D2 choose next read
// - encodings pick low, high, status, invalid
// - zero bit shorts inputs for calibration
// - sleep entered when conversion next ends
// - asleep stops oscillator, port stays alive
// - D6 picks 546 or 655 integrate counts
// - start bit launches one single conversion
// - end flag high at count zero
// - start tested at zero, loads one
// - start bit clears five cycles later
// - late start waits for counter wrap
// - status byte field order fixed
// - result bytes carry B10..B3, B18..B11
// - 8-bit MSB-first packets, latch on select release
// - D0 one writes user pins D4..D7
// - status read clears collision bit
module adc_command_status_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	input  wire logic                i_cs_n,
	input  wire logic                i_sclk,
	input  wire logic                i_din,
	input  wire logic [RESULT_W-1:0] i_result,
	output logic                     o_dout,
	output logic                     o_dout_oe,
	output logic                     o_eoc,
	output logic                     o_integrating,
	output logic                     o_short_inputs,
	output logic                     o_line_50hz,
	output logic                     o_osc_enable,
	output logic [3:0]               o_user_pins
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [2:0]          pin_lvl;        // Filtered cs, sclk, din
	logic [2:0]          pin_rise;       // Rising edges
	logic [2:0]          pin_fall;       // Falling edges
	logic                cs_n;           // Filtered chip select
	logic                cs_rise;        // End of exchange
	logic                cs_fall;        // Start of exchange
	logic                sclk_rise;      // Sample point
	logic                sclk_fall;      // Output change point
	logic                din;            // Filtered data in

	logic [7:0]          in_sr_ff;       // Command shift register
	logic [3:0]          bit_cnt_ff;     // Bits taken this exchange
	logic [7:0]          out_sr_ff;      // Output shift register
	sel_e                rd_sel_ff;      // Register being shifted out
	cmd0_s               cmd0_ff;        // Conversion command
	cmd0_s               nxt_cmd0;       // Next conversion command
	logic [3:0]          pins_ff;        // User output pins
	logic [RESULT_W-1:0] result_ff;      // Latched conversion result
	logic                collision_ff;   // Collision flag
	logic                coll_pend_ff;   // Result changed during a read
	pwr_e                pwr_ff;         // Power state
	pwr_e                nxt_pwr;        // Next power state

	logic                packet_ok;      // Full packet received
	logic                wr_cmd0;        // Latch into conversion command
	logic                wr_cmd1;        // Latch into pin command
	cmd0_s               packet;         // Received packet as command
	sel_e                next_sel;       // Choice for the coming exchange
	status_s             status;         // Assembled status byte
	logic [7:0]          sel_byte;       // Byte to load for shifting
	logic                status_read;    // Status read just finished
	logic                running;        // Oscillator running

	logic [CNT_W-1:0]    count;          // Conversion count
	logic                eoc;            // End of conversion
	logic                integrating;    // Integrate phase
	logic                launch;         // Conversion launched
	logic                conv_end;       // Conversion finishing
	logic                start_clear;    // Start bit self-clear

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	pin_sync #(
		.W(3)
	) u_pin_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_cs_n, i_sclk, i_din}),
		.o_level   (pin_lvl),
		.o_rise    (pin_rise),
		.o_fall    (pin_fall)
	);

	// Pin event decode
	assign cs_n      = pin_lvl[2];
	assign cs_rise   = pin_rise[2];
	assign cs_fall   = pin_fall[2];
	assign sclk_rise = pin_rise[1] && !cs_n;
	assign sclk_fall = pin_fall[1] && !cs_n;
	assign din       = pin_lvl[0];

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	conv_sequencer u_conv_sequencer (
		.i_clk         (i_clk),
		.i_reset_n     (i_reset_n),
		.i_run         (running),
		.i_start       (cmd0_ff.start),
		.i_line_50hz   (cmd0_ff.line_50hz),
		.o_count       (count),
		.o_eoc         (eoc),
		.o_integrating (integrating),
		.o_launch      (launch),
		.o_conv_end    (conv_end),
		.o_start_clear (start_clear)
	);

	////////////////////////////////////////////////////////////////////////////
	// Command input path
	// Shift in MSB first on sclk rise
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			in_sr_ff   <= 8'h00;
			bit_cnt_ff <= 4'h0;
		end else if (cs_fall) begin
			bit_cnt_ff <= 4'h0;
		end else if (sclk_rise) begin
			in_sr_ff   <= {in_sr_ff[6:0], din};
			// Saturate so a long burst keeps the last eight bits
			bit_cnt_ff <= (bit_cnt_ff == PACKET_BITS) ? PACKET_BITS : bit_cnt_ff + 4'h1;
		end
	end

	// latch on select release, D0 picks target
	assign packet    = cmd0_s'(in_sr_ff);
	assign packet_ok = cs_rise && (bit_cnt_ff == PACKET_BITS);
	assign wr_cmd0   = packet_ok && !packet.reg_id;
	assign wr_cmd1   = packet_ok && packet.reg_id;

	// Next conversion command
	always_comb begin
		nxt_cmd0 = cmd0_ff;
		if (wr_cmd0) begin
			// A fresh write wins over the self-clear
			nxt_cmd0 = packet;
		end else if (start_clear) begin
			nxt_cmd0.start = 1'b0;
		end
	end

	// Command registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cmd0_ff <= cmd0_s'(CMD0_RESET);
			pins_ff <= USER_PINS_RESET;
		end else begin
			cmd0_ff <= nxt_cmd0;
			if (wr_cmd1) begin
				pins_ff <= {in_sr_ff[7], in_sr_ff[6], in_sr_ff[5], in_sr_ff[4]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power state
	// sleep taken at the conversion end
	always_comb begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			PWR_AWAKE: begin
				if (conv_end && cmd0_ff.sleep) begin
					nxt_pwr = PWR_ASLEEP;
				end
			end
			PWR_ASLEEP: begin
				// host wakes by clearing the bit
				if (!cmd0_ff.sleep) begin
					nxt_pwr = PWR_AWAKE;
				end
			end
			default: begin
				nxt_pwr = PWR_AWAKE;
			end
		endcase
	end

	// Power state register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pwr_ff <= PWR_AWAKE;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	// oscillator stops, serial port keeps running
	assign running = (pwr_ff == PWR_AWAKE);

	////////////////////////////////////////////////////////////////////////////
	// Result and collision
	// Result latch at each conversion end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			result_ff <= '0;
		end else if (conv_end) begin
			result_ff <= i_result;
		end
	end

	assign status_read = cs_rise && (rd_sel_ff == SEL_STATUS);

	// status read clears, new collision wins
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			coll_pend_ff <= 1'b0;
			collision_ff <= 1'b0;
		end else if (cs_rise) begin
			// A latch in the closing cycle of the frame still counts
			coll_pend_ff <= 1'b0;
			collision_ff <= coll_pend_ff || conv_end || (collision_ff && !status_read);
		end else if (conv_end && !cs_n) begin
			coll_pend_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output register selection
	// status byte fields
	assign status.collision   = collision_ff;
	assign status.eoc         = eoc;
	assign status.integrating = integrating;
	assign status.sleep       = !running;
	assign status.sign        = result_ff[18];
	assign status.low_bits    = result_ff[2:0];

	// choice from the stored select bits
	assign next_sel = decode_sel(cmd0_ff.reg_sel_high, cmd0_ff.reg_sel_low);

	assign sel_byte = (next_sel == SEL_LOW)    ? result_ff[10:3] :
	                  (next_sel == SEL_HIGH)   ? result_ff[18:11] :
	                  (next_sel == SEL_STATUS) ? 8'(status) :
	                  INVALID_BYTE;

	// load on select, shift on sclk fall
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_sr_ff <= 8'h00;
			rd_sel_ff <= SEL_LOW;
		end else if (cs_fall) begin
			out_sr_ff <= sel_byte;
			rd_sel_ff <= next_sel;
		end else if (sclk_fall) begin
			out_sr_ff <= {out_sr_ff[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_dout         = out_sr_ff[7];
	assign o_dout_oe      = !cs_n;
	assign o_eoc          = eoc;
	assign o_integrating  = integrating;
	assign o_short_inputs = cmd0_ff.zero_cal;
	assign o_line_50hz    = cmd0_ff.line_50hz;
	assign o_osc_enable   = running;
	assign o_user_pins    = pins_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_pins_follow_write: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		wr_cmd1 |=> o_user_pins == $past(in_sr_ff[7:4]))
		else $error("user pins did not take command bits");
	a_zero_short: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		wr_cmd0 |=> o_short_inputs == $past(in_sr_ff[4]))
		else $error("short control not from zero bit");
	a_sleep_at_end: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		$fell(running) |-> $past(conv_end) && $past(cmd0_ff.sleep))
		else $error("sleep entered away from conversion end");
	a_asleep_frozen: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		!running && !$past(running) |-> $stable(count))
		else $error("counter moved while asleep");
	a_invalid_zero: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		cs_fall && next_sel == SEL_BAD |=> out_sr_ff == INVALID_BYTE)
		else $error("invalid select did not load zeros");
	a_status_clears: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		status_read && !coll_pend_ff && !conv_end |=> !collision_ff)
		else $error("collision not cleared by status read");
	a_launch_needs_start: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		launch |-> cmd0_ff.start && eoc)
		else $error("conversion launched without start");

endmodule // adc_command_status_sequencer

// ===== core/adc_seq_pkg.sv
// Shared constants, field layouts and types of the converter command sequencer
package adc_seq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Conversion counter
	localparam int          CNT_W           = 11;          // 2048 counts per cycle
	localparam logic [10:0] COUNT_IDLE      = 11'h000;     // End of conversion point
	localparam logic [10:0] COUNT_LAUNCH    = 11'h001;     // First count of a conversion
	localparam logic [10:0] COUNT_LAST      = 11'h7FF;     // Last count before wrap
	localparam logic [10:0] INT_START       = 11'h010;     // Integrate phase opens here
	localparam logic [10:0] INT_LEN_60HZ    = 11'h222;     // 546 counts, one 60 Hz period
	localparam logic [10:0] INT_LEN_50HZ    = 11'h28F;     // 655 counts, one 50 Hz period
	localparam logic [2:0]  START_CLR_CYC   = 3'h5;        // Start bit self-clear delay

	////////////////////////////////////////////////////////////////////////////
	// Serial port
	localparam int          SYNC_STAGES     = 3;           // Pin synchroniser depth
	localparam logic [3:0]  PACKET_BITS     = 4'h8;        // Bits per command packet
	localparam logic [7:0]  INVALID_BYTE    = 8'h00;       // Output for invalid select

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  CMD0_RESET      = 8'h00;       // Awake, 60 Hz, no start
	localparam logic [3:0]  USER_PINS_RESET = 4'h0;        // User outputs low
	localparam int          RESULT_W        = 19;          // B18..B0

	// Conversion command layout, D7 first
	typedef struct packed {
		logic start;         // D7 start convert
		logic line_50hz;     // D6 line rate
		logic sleep;         // D5 sleep request
		logic zero_cal;      // D4 zero calibrate
		logic unused;        // D3 don't care
		logic reg_sel_low;   // D2 reg_select_low
		logic reg_sel_high;  // D1 reg_select_high
		logic reg_id;        // D0 register identifier
	} cmd0_s;

	// Status byte layout, D7 first
	typedef struct packed {
		logic       collision;    // D7
		logic       eoc;          // D6
		logic       integrating;  // D5
		logic       sleep;        // D4
		logic       sign;         // D3, 1 means negative
		logic [2:0] low_bits;     // D2..D0 = B2..B0
	} status_s;

	// Output register choice
	typedef enum logic [1:0] {
		SEL_LOW,
		SEL_HIGH,
		SEL_STATUS,
		SEL_BAD
	} sel_e;

	// Power state
	typedef enum logic {
		PWR_AWAKE,
		PWR_ASLEEP
	} pwr_e;

	// Decode the two select bits into an output choice
	function automatic sel_e decode_sel(input logic high, input logic low);
		if (!high && !low) begin
			return SEL_LOW;
		end else if (!high && low) begin
			return SEL_HIGH;
		end else if (high && !low) begin
			return SEL_STATUS;
		end else begin
			return SEL_BAD;
		end
	endfunction

endpackage

// ===== core/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sync
	import adc_seq_pkg::*;
#(
	parameter int W = 3
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);

	logic [W-1:0] s1_ff;      // First stage, read by s2 only
	logic [W-1:0] s2_ff;      // Second stage
	logic [W-1:0] s3_ff;      // Third stage
	logic [W-1:0] level_ff;   // Filtered level
	logic [W-1:0] agree;      // Stages two and three match
	logic [W-1:0] nxt_level;  // Level after filter

	// Level moves only when the last two stages agree
	assign agree     = ~(s2_ff ^ s3_ff);
	assign nxt_level = (agree & s2_ff) | (~agree & level_ff);

	// Synchroniser chain and filter
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_ff    <= '1;
			s2_ff    <= '1;
			s3_ff    <= '1;
			level_ff <= '1;
		end else begin
			s1_ff    <= i_async;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	// Edge pulses, one cycle each
	assign o_level = level_ff;
	assign o_rise  = nxt_level & ~level_ff;
	assign o_fall  = ~nxt_level & level_ff;

endmodule // pin_sync

// ===== core/conv_sequencer.sv
// Conversion counter, end-of-conversion, integrate window and start self-clear
`timescale 1ns/1ps
module conv_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_run,
	input  wire logic        i_start,
	input  wire logic        i_line_50hz,
	output logic [CNT_W-1:0] o_count,
	output logic             o_eoc,
	output logic             o_integrating,
	output logic             o_launch,
	output logic             o_conv_end,
	output logic             o_start_clear
);

	logic [CNT_W-1:0] count_ff;      // Conversion counter
	logic [CNT_W-1:0] nxt_count;     // Next count
	logic             eoc_ff;        // End of conversion flag
	logic             integ_ff;      // Integrate phase flag
	logic             nxt_integ;     // Next integrate flag
	logic [2:0]       clr_ff;        // Start self-clear timer
	logic [CNT_W-1:0] int_len;       // Selected integrate length
	logic [CNT_W-1:0] int_end;       // Integrate close count
	logic             at_idle;       // Counter at 0000

	assign at_idle  = (count_ff == COUNT_IDLE);
	assign o_launch = i_run && at_idle && i_start;
	// late start waits for the wrap
	assign o_conv_end = i_run && (count_ff == COUNT_LAST);
	assign int_len  = i_line_50hz ? INT_LEN_50HZ : INT_LEN_60HZ;
	assign int_end  = INT_START + int_len;

	assign nxt_count = !i_run ? count_ff :
	                   at_idle ? (i_start ? COUNT_LAUNCH : COUNT_IDLE) :
	                   count_ff + COUNT_LAUNCH;
	assign nxt_integ = (nxt_count >= INT_START) && (nxt_count < int_end);

	// Counter and flags
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_ff <= COUNT_IDLE;
			eoc_ff   <= 1'b1;
			integ_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			eoc_ff   <= (nxt_count == COUNT_IDLE);
			integ_ff <= nxt_integ;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clr_ff <= 3'h0;
		end else if (o_launch) begin
			clr_ff <= 3'h1;
		end else if (clr_ff == START_CLR_CYC) begin
			clr_ff <= 3'h0;
		end else if (clr_ff != 3'h0 && i_run) begin
			clr_ff <= clr_ff + 3'h1;
		end
	end

	assign o_start_clear = (clr_ff == START_CLR_CYC);
	assign o_count       = count_ff;
	assign o_eoc         = eoc_ff;
	assign o_integrating = integ_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_launch_loads_one: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_launch |=> (count_ff == COUNT_LAUNCH) && !eoc_ff)
		else $error("launch did not load count one");
	a_eoc_at_wrap: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		$rose(eoc_ff) |-> $past(count_ff) == COUNT_LAST)
		else $error("eoc rose away from wrap");
	a_clear_after_five: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_launch ##1 i_run [*4] |=> o_start_clear)
		else $error("start clear not five cycles after launch");
	a_no_midrun_launch: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		(count_ff > START_CLR_CYC) && i_run |=> count_ff != COUNT_LAUNCH)
		else $error("conversion launched before wrap");
	a_integ_opens: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		$rose(integ_ff) |-> count_ff == INT_START)
		else $error("integrate phase opened at wrong count");

endmodule // conv_sequencer

// ===== tb/host_model.sv
// Host side of the four-wire serial port, one task per exchange
`timescale 1ns/1ps
module host_model (
	input  wire logic i_clk,   // Bench clock
	input  wire logic i_dout,  // Serial data from the block
	output logic      o_cs_n,  // Chip select, active low
	output logic      o_sclk,  // Shift clock, still outside frames
	output logic      o_din    // Serial command data
);
	////////////////////////////////////////////////////////////////////////////
	// Idle levels at time zero
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One exchange: command in, selected byte out
	task automatic exchange(input logic [7:0] cmd, output logic [7:0] rd);
		@(posedge i_clk) o_cs_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		// MSB first, rise samples, fall shifts
		for (int i = 7; i >= 0; i--) begin
			o_din <= cmd[i];
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b1;
			// Previous fall has reached the shift register by now
			@(negedge i_clk) rd[i] = i_dout;
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b0;
		end
		repeat (6) @(posedge i_clk);
		// Packet latches here; data line no longer held
		o_cs_n <= 1'b1;
		o_din  <= ~o_din;
		repeat (8) @(posedge i_clk);
		// Hand back away from the clock edge so outputs are settled
		@(negedge i_clk);
	endtask
endmodule // host_model

// ===== tb/adc_command_status_sequencer_tb_top.sv
// Self-checking bench of the converter command sequencer
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module adc_command_status_sequencer_tb_top;
	import adc_seq_pkg::*;
	logic                clk = 1'b0;          // 10 MHz clock
	logic                reset_n = 1'b0;      // Async reset, active low
	logic [RESULT_W-1:0] res = 19'h5_A5C3;    // Results counter value
	wire logic           cs_n, sclk, din;     // Host pins
	logic                dout, dout_oe, eoc, integ, short_in, line_50, osc_en;
	logic [3:0]          upins;               // User output pins
	int                  n_fail = 0;          // Mismatches
	int                  checks_done = 0;     // Comparisons

	always #50 clk = ~clk;

	host_model host_u (.i_clk(clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

	adc_command_status_sequencer dut_u (
		.i_clk(clk), .i_reset_n(reset_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
		.i_result(res), .o_dout(dout), .o_dout_oe(dout_oe), .o_eoc(eoc),
		.o_integrating(integ), .o_short_inputs(short_in), .o_line_50hz(line_50),
		.o_osc_enable(osc_en), .o_user_pins(upins));

	////////////////////////////////////////////////////////////////////////////
	// Wait for eoc level, counting cycles and integrate cycles
	task automatic wait_eoc(input logic lvl, output int n, output int ni);
		n  = 0;
		ni = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (integ === 1'b1) ni++;
		end while (eoc !== lvl && n < 3000);
		if (n >= 3000) n_fail++;
	endtask

	// Pin command drives user pins, leaves conversion command alone
	task automatic t_pins();
		logic [7:0] rd;
		host_u.exchange(8'hA1, rd);
		`CHECK("user pins A", 4'hA, upins)
		host_u.exchange(8'h51, rd);
		`CHECK("user pins 5", 4'h5, upins)
		`CHECK("short kept", 1'b0, short_in)
	endtask

	// Zero calibrate and line rate follow D4 and D6
	task automatic t_config();
		logic [7:0] rd;
		host_u.exchange(8'h50, rd);
		`CHECK("short on", 1'b1, short_in)
		`CHECK("line 50", 1'b1, line_50)
		host_u.exchange(8'h00, rd);
		`CHECK("short off", 1'b0, short_in)
		`CHECK("line 60", 1'b0, line_50)
	endtask

	// Single 60 Hz conversion: length, integrate span, no relaunch
	task automatic t_conv60();
		logic [7:0] rd;
		int         n, ni;
		// Watch eoc from the frame start so the fall edge is not missed
		fork
			host_u.exchange(8'h80, rd);
			begin
				wait_eoc(1'b0, n, ni);
				wait_eoc(1'b1, n, ni);
			end
		join
		`CHECK("conv cycles", 2047, n)
		`CHECK("int 60", 546, ni)
		repeat (40) @(posedge clk);
		#1;
		`CHECK("idle after end", 1'b1, eoc)
	endtask

	// Select in one exchange, read in the next
	task automatic t_reads();
		logic [7:0] rd;
		logic [7:0] sel [5] = '{8'h00, 8'h04, 8'h02, 8'h06, 8'h00};
		logic [7:0] ex  [4];
		ex[0] = res[10:3];
		ex[1] = res[18:11];
		ex[2] = {1'b0, 1'b1, 1'b0, 1'b0, res[18], res[2:0]};
		ex[3] = INVALID_BYTE;
		// select first, data on next exchange
		host_u.exchange(sel[0], rd);
		for (int i = 1; i < 5; i++) begin
			host_u.exchange(sel[i], rd);
			`CHECK("read byte", ex[i-1], rd)
		end
	endtask

	// Result latched inside a frame sets collision; status read clears it
	task automatic t_collision();
		logic [7:0] rd;
		host_u.exchange(8'h80, rd);
		// Next frame spans the conversion end
		repeat (2000) @(posedge clk);
		host_u.exchange(8'h02, rd);
		host_u.exchange(8'h02, rd);
		`CHECK("collision set", 2'b11, rd[7:6])
		host_u.exchange(8'h00, rd);
		`CHECK("collision cleared", 1'b0, rd[7])
	endtask

	// Start written mid-conversion waits for wrap, then 50 Hz span
	task automatic t_pending();
		logic [7:0] rd;
		int         n, ni;
		host_u.exchange(8'h80, rd);
		wait_eoc(1'b0, n, ni);
		repeat (100) @(posedge clk);
		// pre-write start before the conversion ends
		host_u.exchange(8'hC0, rd);
		`CHECK("still running", 1'b0, eoc)
		wait_eoc(1'b1, n, ni);
		wait_eoc(1'b0, n, ni);
		`CHECK("relaunch gap", 1'b1, n <= 3)
		wait_eoc(1'b1, n, ni);
		`CHECK("int 50", 655, ni)
		repeat (40) @(posedge clk);
		#1;
		`CHECK("start cleared", 1'b1, eoc)
	endtask

	// Sleep waits for conversion end; port stays alive asleep
	task automatic t_sleep();
		logic [7:0] rd;
		int         n, ni;
		host_u.exchange(8'hA0, rd);
		wait_eoc(1'b0, n, ni);
		`CHECK("awake running", 1'b1, osc_en)
		wait_eoc(1'b1, n, ni);
		repeat (3) @(posedge clk);
		#1;
		`CHECK("asleep", 1'b0, osc_en)
		host_u.exchange(8'h22, rd);
		host_u.exchange(8'h00, rd);
		`CHECK("status asleep", 2'b11, {rd[6], rd[4]})
		`CHECK("woken", 1'b1, osc_en)
		// settle 2100 cycles before the next start
		repeat (2100) @(posedge clk);
		host_u.exchange(8'h80, rd);
		wait_eoc(1'b0, n, ni);
		`CHECK("start after wake", 1'b1, n < 20)
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog cuts a hang short
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHECK("reset out", 8'h90, {eoc, integ, short_in, osc_en, upins})
		`CHECK("reset oe", 1'b0, dout_oe)
		t_pins();
		t_config();
		t_conv60();
		t_reads();
		t_collision();
		t_pending();
		t_sleep();
		print_verdict();
	end
endmodule // adc_command_status_sequencer_tb_top
